/* File: rtl/tpp_port.sv */
`timescale 1ns/1ps
module tpp_port
  import tpp_pkg::*;
#(
  parameter logic [7:0] NULL_CODE   = TPP_NULL_CODE,
  parameter logic [7:0] XFER_CODE   = TPP_TRANSFER_CODE,
  parameter logic [7:0] RSREQ_CODE  = TPP_COMMAND_A_REQ_CODE,
  parameter logic [7:0] RSACK_CODE  = TPP_COMMAND_A_ACK_CODE,
  parameter int unsigned BYTE_CYC   = TPP_BYTE_CYC
) (
  input  wire logic          i_mclk,
  input  wire logic          i_rst,
  input  wire logic [1:0]    i_mode,
  input  wire logic          i_pins_cfg,
  input  wire logic          i_peer_reset,
  input  wire tpp_pins_in_t  i_pins,
  input  wire logic          i_out_request,
  input  wire logic [7:0]    i_tx_len,
  input  wire logic          i_tx_wr,
  input  wire logic [7:0]    i_tx_addr,
  input  wire logic [7:0]    i_tx_data,
  input  wire logic [7:0]    i_rx_cap,
  input  wire logic          i_rx_read,
  input  wire logic [7:0]    i_rx_addr,
  output tpp_pins_out_t      o_pins,
  output logic               o_synced,
  output logic               o_has_token,
  output logic               o_out_permitted,
  output logic               o_out_req_flag,
  output logic               o_in_pending,
  output logic               o_rx_done,
  output logic [7:0]         o_rx_len,
  output logic [7:0]         o_rx_data,
  output logic               o_tx_done
);
  // Slave-only datapath; master mode runs the same framing as a sender
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_CMD   = 9'h002,
    ST_LEN   = 9'h004,
    ST_DATA  = 9'h008,
    ST_EOMR  = 9'h010,
    ST_TCMD  = 9'h020,
    ST_TLEN  = 9'h040,
    ST_TDATA = 9'h080,
    ST_TEOM  = 9'h100
  } tpp_state_t;

  tpp_state_t state_r, state_nxt;
  logic [7:0] cnt_r, cnt_nxt, len_r, len_nxt, rxlen_r, rxlen_nxt;
  logic [7:0] obyte_r, obyte_nxt;
  logic       busy_r, busy_nxt, synced_r, synced_nxt, token_r, token_nxt;
  logic       oreq_r, oreq_nxt, pend_r, pend_nxt, rxd_r, rxd_nxt;
  logic       txd_r, txd_nxt, oe_r, oe_nxt, cfg_r, cfg_nxt, rsack_r;
  logic       rsack_nxt, cs_q_r, rate_ok, wr_we;
  logic       rxm_r, rxm_nxt, snd_r, snd_nxt;
  logic [15:0] pace_r, pace_nxt;
  logic [7:0]  mrd;

  function automatic logic is_slave(input logic [1:0] m);
    return m != TPP_MODE_MASTER;
  endfunction

  // Strobe rising edge = master access complete
  wire strobe_up = !cs_q_r && i_pins.cs_n;
  wire ctrl_rd   = (i_mode == TPP_MODE_SLAVE_BUS) &&
                   i_pins.register_select && i_pins.rd_nwr;
  wire mwrite    = strobe_up && !i_pins.rd_nwr && !i_pins.register_select;
  wire mread     = strobe_up && i_pins.rd_nwr && !ctrl_rd;
  // Slave-side step allowed while busy is high
  wire my_turn   = busy_r;

  assign rate_ok = (pace_r == 16'h0000);
  assign wr_we   = (state_r == ST_DATA) && my_turn;

  tpp_mem #(.DEPTH(TPP_MEM_DEPTH), .AW(8)) u_rx (
    .i_mclk (i_mclk),
    .i_we   (wr_we),
    .i_waddr(cnt_r),
    .i_wdata(i_pins.data),
    .i_raddr(i_rx_addr),
    .o_rdata(o_rx_data)
  );

  tpp_mem #(.DEPTH(TPP_MEM_DEPTH), .AW(8)) u_tx (
    .i_mclk (i_mclk),
    .i_we   (i_tx_wr),
    .i_waddr(i_tx_addr),
    .i_wdata(i_tx_data),
    .i_raddr(cnt_nxt),
    .o_rdata(mrd)
  );

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    len_nxt   = len_r;
    rxlen_nxt = rxlen_r;
    obyte_nxt = obyte_r;
    busy_nxt  = busy_r;
    synced_nxt = synced_r;
    token_nxt = token_r;
    oreq_nxt  = oreq_r | i_out_request;
    pend_nxt  = pend_r;
    rxd_nxt   = 1'b0;
    txd_nxt   = 1'b0;
    oe_nxt    = oe_r;
    cfg_nxt   = cfg_r | i_pins_cfg;
    rsack_nxt = rsack_r;
    rxm_nxt   = rxm_r;
    snd_nxt   = snd_r;
    pace_nxt  = (pace_r != 16'h0000) ? pace_r - 16'h0001 : pace_r;
    if (i_rx_read) begin
      pend_nxt = 1'b0;
    end
    if (strobe_up && !ctrl_rd) begin
      busy_nxt = 1'b1;
    end
    if (i_peer_reset) begin
      synced_nxt = 1'b0;
      state_nxt  = ST_IDLE;
      token_nxt  = 1'b0;
      busy_nxt   = 1'b0;
      oe_nxt     = 1'b0;
      rsack_nxt  = 1'b0;
    end else if (!cfg_r) begin
      oe_nxt = 1'b0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (!is_slave(i_mode) && !synced_r) begin
            // Master opens with a command_a request
            synced_nxt = 1'b1;
            token_nxt  = 1'b1;
            obyte_nxt  = RSREQ_CODE;
            oe_nxt     = 1'b1;
            snd_nxt    = 1'b0;
            state_nxt  = ST_TCMD;
          end else if (my_turn) begin
            state_nxt = ST_CMD;
          end
        end
        ST_CMD: begin
          // Read the command the master wrote
          if (my_turn) begin
            busy_nxt = 1'b0;
            if (i_pins.data == RSREQ_CODE) begin
              synced_nxt = 1'b1;
              rsack_nxt  = 1'b1;
              state_nxt  = ST_EOMR;
            end else if (!synced_r) begin
              state_nxt = ST_IDLE;
            end else if (i_pins.data == XFER_CODE) begin
              state_nxt = ST_LEN;
            end else begin
              state_nxt = ST_EOMR;
            end
          end
        end
        ST_LEN: begin
          if (my_turn) begin
            len_nxt   = i_pins.data;
            cnt_nxt   = 8'h00;
            rxm_nxt   = 1'b1;
            busy_nxt  = 1'b0;
            state_nxt = (i_pins.data == 8'h00) ? ST_EOMR : ST_DATA;
          end
        end
        ST_DATA: begin
          if (my_turn) begin
            cnt_nxt  = cnt_r + 8'h01;
            busy_nxt = 1'b0;
            if (cnt_r + 8'h01 == len_r) begin
              state_nxt = ST_EOMR;
            end
          end
        end
        ST_EOMR: begin
          // End-of-message byte is not read; its access clears busy, takes the token, ends reception and picks the reply
          if (my_turn) begin
            busy_nxt  = 1'b0;
            token_nxt = 1'b1;
            oe_nxt    = 1'b1;
            rxm_nxt   = 1'b0;
            snd_nxt   = 1'b0;
            state_nxt = ST_TCMD;
            if (rxm_r) begin
              rxlen_nxt = (len_r <= i_rx_cap) ? len_r : 8'h00;
              pend_nxt  = 1'b1;
              rxd_nxt   = 1'b1;
            end
            if (rsack_r) begin
              obyte_nxt = RSACK_CODE;
            end else if (oreq_r) begin
              obyte_nxt = XFER_CODE;
              snd_nxt   = 1'b1;
            end else begin
              obyte_nxt = NULL_CODE;
            end
          end
        end
        ST_TCMD: begin
          // First reply byte taken by the master
          if (my_turn) begin
            busy_nxt = 1'b0;
            cnt_nxt  = 8'h00;
            if (snd_r) begin
              obyte_nxt = i_tx_len;
              len_nxt   = i_tx_len;
              state_nxt = ST_TLEN;
            end else begin
              obyte_nxt = TPP_EOM_BYTE;
              state_nxt = ST_TEOM;
            end
          end
        end
        ST_TLEN: begin
          if (my_turn && rate_ok) begin
            busy_nxt = 1'b0;
            if (len_r == 8'h00) begin
              obyte_nxt = TPP_EOM_BYTE;
              oreq_nxt  = i_out_request;
              txd_nxt   = 1'b1;
              state_nxt = ST_TEOM;
            end else begin
              pace_nxt  = 16'(BYTE_CYC - 1);
              obyte_nxt = mrd;
              cnt_nxt   = 8'h01;
              state_nxt = ST_TDATA;
            end
          end
        end
        ST_TDATA: begin
          if (my_turn && rate_ok) begin
            busy_nxt = 1'b0;
            if (cnt_r == len_r) begin
              obyte_nxt = TPP_EOM_BYTE;
              oreq_nxt  = i_out_request;
              txd_nxt   = 1'b1;
              state_nxt = ST_TEOM;
            end else begin
              pace_nxt  = 16'(BYTE_CYC - 1);
              obyte_nxt = mrd;
              cnt_nxt   = cnt_r + 8'h01;
            end
          end
        end
        ST_TEOM: begin
          // End byte taken; hand the token back
          if (my_turn) begin
            busy_nxt  = 1'b0;
            token_nxt = 1'b0;
            oe_nxt    = 1'b0;
            rsack_nxt = 1'b0;
            state_nxt = ST_IDLE;
          end
        end
        default: state_nxt = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      state_r  <= ST_IDLE;
      cnt_r    <= 8'h00;
      len_r    <= 8'h00;
      rxlen_r  <= 8'h00;
      obyte_r  <= 8'h00;
      busy_r   <= 1'b0;
      synced_r <= 1'b0;
      token_r  <= 1'b0;
      oreq_r   <= 1'b0;
      pend_r   <= 1'b0;
      rxd_r    <= 1'b0;
      txd_r    <= 1'b0;
      oe_r     <= 1'b0;
      cfg_r    <= 1'b0;
      rsack_r  <= 1'b0;
      rxm_r    <= 1'b0;
      snd_r    <= 1'b0;
      pace_r   <= 16'h0000;
      cs_q_r   <= 1'b1;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      len_r    <= len_nxt;
      rxlen_r  <= rxlen_nxt;
      obyte_r  <= obyte_nxt;
      busy_r   <= busy_nxt;
      synced_r <= synced_nxt;
      token_r  <= token_nxt;
      oreq_r   <= oreq_nxt;
      pend_r   <= pend_nxt;
      rxd_r    <= rxd_nxt;
      txd_r    <= txd_nxt;
      oe_r     <= oe_nxt;
      cfg_r    <= cfg_nxt;
      rsack_r  <= rsack_nxt;
      rxm_r    <= rxm_nxt;
      snd_r    <= snd_nxt;
      pace_r   <= pace_nxt;
      cs_q_r   <= i_pins.cs_n;
    end
  end

  logic [7:0] dout_r;
  logic       doe_n_r, bsy_oe_n_r, permit_r;
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      dout_r     <= 8'h00;
      doe_n_r    <= 1'b1;
      bsy_oe_n_r <= 1'b1;
      permit_r   <= 1'b0;
    end else begin
      // Control read returns busy on bit 0, others zero
      dout_r <= ctrl_rd ? {7'h00, busy_r} : obyte_r;
      doe_n_r <= !(cfg_r && i_pins.rd_nwr && !i_pins.cs_n &&
                   (oe_r || ctrl_rd));
      bsy_oe_n_r <= !(cfg_r && i_mode == TPP_MODE_SLAVE_HS);
      permit_r <= oreq_r && token_r && synced_r;
    end
  end

  assign o_pins.data            = dout_r;
  assign o_pins.data_oe_n       = doe_n_r;
  assign o_pins.slave_busy      = busy_r;
  assign o_pins.slave_busy_oe_n = bsy_oe_n_r;
  assign o_synced        = synced_r;
  assign o_has_token     = token_r;
  assign o_out_permitted = permit_r;
  assign o_out_req_flag  = oreq_r;
  assign o_in_pending    = pend_r;
  assign o_rx_done       = rxd_r;
  assign o_rx_len        = rxlen_r;
  assign o_tx_done       = txd_r;
endmodule

/* File: rtl/tpp_pkg.sv */
package tpp_pkg;

  localparam logic [1:0] TPP_MODE_MASTER  = 2'h0;
  localparam logic [1:0] TPP_MODE_SLAVE_HS = 2'h1;
  localparam logic [1:0] TPP_MODE_SLAVE_BUS = 2'h2;

  // Command byte encodings, arbitrary defaults
  localparam logic [7:0] TPP_NULL_CODE      = 8'h00;
  localparam logic [7:0] TPP_TRANSFER_CODE  = 8'h01;
  localparam logic [7:0] TPP_COMMAND_A_REQ_CODE = 8'h5a;
  localparam logic [7:0] TPP_COMMAND_A_ACK_CODE = 8'h07;
  localparam logic [7:0] TPP_EOM_BYTE       = 8'h00;

  localparam int unsigned TPP_MAX_LEN   = 255;
  localparam int unsigned TPP_CTRL_BUSY_BIT = 0;

  // Data-phase peak rate: one byte per 2400 ns
  localparam int unsigned TPP_CLK_MHZ      = 200;
  localparam int unsigned TPP_BYTE_TIME_NS = 2400;
  localparam int unsigned TPP_BYTE_CYC =
    (TPP_BYTE_TIME_NS * TPP_CLK_MHZ) / 1000;

  localparam int unsigned TPP_MEM_DEPTH = 256;

  typedef struct packed {
    logic       cs_n;
    logic       rd_nwr;
    logic       register_select;
    logic [7:0] data;
  } tpp_pins_in_t;

  typedef struct packed {
    logic [7:0] data;
    logic       data_oe_n;
    logic       slave_busy;
    logic       slave_busy_oe_n;
  } tpp_pins_out_t;

endpackage

/* File: rtl/tpp_mem.sv */
`timescale 1ns/1ps
module tpp_mem
  import tpp_pkg::*;
#(
  parameter int unsigned DEPTH = TPP_MEM_DEPTH,
  parameter int unsigned AW    = 8
) (
  input  wire logic          i_mclk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [7:0]    i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [7:0]    o_rdata
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end
endmodule

/* File: verif/tpp_port_props.sv */
`timescale 1ns/1ps
module tpp_port_props
  import tpp_pkg::*;
(
  input  wire logic          i_mclk,
  input  wire logic          i_rst,
  input  wire logic [1:0]    i_mode,
  input  wire logic          i_pins_cfg,
  input  wire logic          i_peer_reset,
  input  wire tpp_pins_in_t  i_pins,
  input  wire logic          i_out_request,
  input  wire logic [7:0]    i_rx_cap,
  input  wire logic          i_rx_read,
  input  wire tpp_pins_out_t o_pins,
  input  wire logic          o_synced,
  input  wire logic          o_has_token,
  input  wire logic          o_out_permitted,
  input  wire logic          o_out_req_flag,
  input  wire logic          o_in_pending,
  input  wire logic          o_rx_done,
  input  wire logic [7:0]    o_rx_len,
  input  wire logic          o_tx_done
);
  logic cfg_r;
  always_ff @(posedge i_mclk) cfg_r <= i_rst ? 1'h0 : (cfg_r | i_pins_cfg);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_rst);
  pins_stay_in_a: assert property (!cfg_r && !i_pins_cfg |->
    o_pins.data_oe_n && o_pins.slave_busy_oe_n) else $error("pins driven");
  reset_state_a: assert property ($past(i_rst) |->
    !o_synced && !o_has_token) else $error("bad state after reset");
  busy_rise_a: assert property (cfg_r && i_mode != TPP_MODE_SLAVE_BUS
    && $rose(i_pins.cs_n) |=> o_pins.slave_busy) else $error("busy low");
  rx_cap_a: assert property (o_rx_done |-> o_rx_len <= i_rx_cap)
    else $error("length above capacity");
  pend_set_a: assert property (o_rx_done |-> ##[0:1] o_in_pending)
    else $error("pending not raised");
  pend_clr_a: assert property (i_rx_read && o_in_pending && !o_rx_done
    |=> !o_in_pending) else $error("pending not consumed");
  out_permit_a: assert property (o_out_permitted |-> o_out_req_flag ||
    $past(o_out_req_flag)) else $error("permit without request");
  tx_clear_a: assert property (o_tx_done && !i_out_request
    |=> !o_out_req_flag) else $error("request flag kept");
  keep_token_a: assert property (o_has_token && o_out_req_flag &&
    !o_tx_done && !i_peer_reset |=> o_has_token) else $error("token lost");
  peer_drop_a: assert property (i_peer_reset |=> !o_synced)
    else $error("sync kept over peer reset");
endmodule

bind tpp_port tpp_port_props i_tpp_port_props (.*);

/* File: verif/tpp_host.sv */
`timescale 1ns/1ps
module tpp_host
  import tpp_pkg::*;
(
  input  wire tpp_pins_out_t i_dev,
  input  wire logic          i_mclk,
  output tpp_pins_in_t       o_pins
);
  logic       cs  = 1'h1;
  logic       rd  = 1'h0;
  logic [7:0] drv = 8'h00;
  logic       busy;
  // Busy line pulled up while released
  assign busy = i_dev.slave_busy_oe_n ? 1'h1 : i_dev.slave_busy;
  // Undriven data shows the inverse of drv, the byte passed to the current access
  assign o_pins = '{cs_n: cs, rd_nwr: rd, register_select: 1'h0,
    data: !rd ? drv : (i_dev.data_oe_n ? ~drv : i_dev.data)};
  task automatic acc(input logic r, input logic [7:0] d,
                     output logic [7:0] q);
    int n;
    n = 0;
    #1;
    while (busy !== 1'h0 && n < 4000) begin
      @(posedge i_mclk);
      #1;
      n++;
    end
    @(posedge i_mclk);
    rd  <= r;
    drv <= d;
    cs  <= 1'h0;
    repeat (2) @(posedge i_mclk);
    q = o_pins.data;
    cs <= 1'h1;
    repeat (2) @(posedge i_mclk);
  endtask
endmodule

/* File: verif/tpp_port_bench.sv */
`timescale 1ns/1ps
module tpp_port_bench
  import tpp_pkg::*;
;
  logic          mclk = 1'h0, rst = 1'h1, cfg = 1'h0, peer = 1'h0;
  logic          oreq = 1'h0, txwr = 1'h0, rxrd = 1'h0;
  logic [1:0]    mode = TPP_MODE_SLAVE_HS;
  logic [7:0]    txlen = 8'h00, txa = 8'h00, txd = 8'h00;
  logic [7:0]    cap = 8'hff, rxa = 8'h00, rxlen, rxdat;
  logic          synced, tok, perm, oflag, pend, rxdone, txdone;
  tpp_pins_in_t  pin;
  tpp_pins_out_t pout;
  int            n_mismatch = 0, checks = 0, nrx = 0, ntx = 0, k, i;

  always #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    if (rxdone === 1'h1)
      nrx <= nrx + 1;
    if (txdone === 1'h1)
      ntx <= ntx + 1;
  end

  tpp_host i_tpp_host (.i_dev(pout), .i_mclk(mclk), .o_pins(pin));
  tpp_port #(.BYTE_CYC(4)) i_tpp_port (
    .i_mclk(mclk), .i_rst(rst), .i_mode(mode), .i_pins_cfg(cfg),
    .i_peer_reset(peer), .i_pins(pin), .i_out_request(oreq),
    .i_tx_len(txlen), .i_tx_wr(txwr), .i_tx_addr(txa), .i_tx_data(txd),
    .i_rx_cap(cap), .i_rx_read(rxrd), .i_rx_addr(rxa), .o_pins(pout),
    .o_synced(synced), .o_has_token(tok), .o_out_permitted(perm),
    .o_out_req_flag(oflag), .o_in_pending(pend), .o_rx_done(rxdone),
    .o_rx_len(rxlen), .o_rx_data(rxdat), .o_tx_done(txdone));

  task automatic test_done;
    if (n_mismatch == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h, want %h", $time, s, e);
    end
  endtask
  task automatic tick;
    @(posedge mclk);
    #1;
  endtask
  task automatic put(input logic [7:0] d);
    logic [7:0] q;
    i_tpp_host.acc(1'h0, d, q);
  endtask
  task automatic get(input logic [7:0] e, input bit c);
    logic [7:0] q;
    i_tpp_host.acc(1'h1, 8'h00, q);
    if (c)
      chk(q, e);
  endtask
  // Transfer code, length, data, end of message
  task automatic xfer(input int n);
    put(TPP_TRANSFER_CODE);
    put(8'(n));
    for (int j = 0; j < n; j++)
      put(8'h30 + 8'(j));
    put(TPP_EOM_BYTE);
  endtask

  initial begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    test_done;
  end

  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'h0;
    tick;
    chk(8'(pout.data_oe_n), 8'h01);
    chk(8'(pout.slave_busy_oe_n), 8'h01);
    chk(8'(tok), 8'h00);
    @(posedge mclk);
    cfg <= 1'h1;
    @(posedge mclk);
    cfg <= 1'h0;
    xfer(1);
    tick;
    chk(8'(nrx), 8'h00);
    chk(8'(synced), 8'h00);
    put(TPP_COMMAND_A_REQ_CODE);
    put(TPP_EOM_BYTE);
    get(TPP_COMMAND_A_ACK_CODE, 1);
    get(8'h00, 0);
    tick;
    chk(8'(synced), 8'h01);
    for (k = 0; k < 2; k++) begin
      @(posedge mclk);
      cap <= k ? 8'h02 : 8'hff;
      xfer(3);
      tick;
      chk(8'(nrx), 8'(k + 1));
      chk(rxlen, k ? 8'h00 : 8'h03);
      chk(8'(pend), 8'h01);
      for (i = 0; i < 3 && k == 0; i++) begin
        @(posedge mclk);
        rxa <= 8'(i);
        tick;
        chk(rxdat, 8'h30 + 8'(i));
      end
      @(posedge mclk);
      rxrd <= 1'h1;
      @(posedge mclk);
      rxrd <= 1'h0;
      tick;
      chk(8'(pend), 8'h00);
      get(TPP_NULL_CODE, 1);
      get(8'h00, 0);
    end
    for (i = 0; i < 2; i++) begin
      @(posedge mclk);
      txwr <= 1'h1;
      txa  <= 8'(i);
      txd  <= 8'hc0 + 8'(i);
    end
    @(posedge mclk);
    txwr  <= 1'h0;
    txlen <= 8'h02;
    oreq  <= 1'h1;
    @(posedge mclk);
    oreq <= 1'h0;
    tick;
    chk(8'(oflag), 8'h01);
    put(TPP_NULL_CODE);
    put(TPP_EOM_BYTE);
    get(TPP_TRANSFER_CODE, 1);
    chk(8'(perm), 8'h01);
    chk(8'(tok), 8'h01);
    get(8'h02, 1);
    for (i = 0; i < 2; i++)
      get(8'hc0 + 8'(i), 1);
    get(8'h00, 0);
    tick;
    chk(8'(ntx), 8'h01);
    chk(8'(oflag), 8'h00);
    @(posedge mclk);
    peer <= 1'h1;
    @(posedge mclk);
    peer <= 1'h0;
    tick;
    chk(8'(synced), 8'h00);
    test_done;
  end
endmodule
